// >>> rtl/scr_pkg.sv
package scr_pkg;

  // Geometry of the register space
  localparam int          REG_W      = 32;
  localparam int          OFS_W      = 24;
  localparam int          CNT_W      = 4;
  localparam int          OP_COUNT   = 10;
  localparam int          IMPL_COUNT = 4;
  localparam int          WORD_LSB   = 2;

  // Byte offsets of the two capability words and the space limits
  localparam logic [23:0] SRC_OPS_OFS = 24'h000018;
  localparam logic [23:0] TGT_OPS_OFS = 24'h00001C;
  localparam logic [23:0] CAP_LAST    = 24'h00003C;
  localparam logic [23:0] CSR_LAST    = 24'h0000FC;
  localparam logic [23:0] EXT_LAST    = 24'h00FFFC;
  localparam logic [23:0] WORD_STEP   = 24'h000004;

  // Operation flag positions, numbered with bit 0 as the word's MSB
  localparam int OP_READ    = 0;
  localparam int OP_IREAD   = 1;
  localparam int OP_RFO     = 2;
  localparam int OP_DINV    = 3;
  localparam int OP_CASTOUT = 4;
  localparam int OP_DFLUSH  = 5;
  localparam int OP_IOREAD  = 6;
  localparam int OP_IINV    = 7;
  localparam int OP_TLBIE   = 8;
  localparam int OP_TLBSYNC = 9;

  // Implementation-defined flag positions, same numbering
  localparam int IMPL_POS0 = 14;
  localparam int IMPL_POS1 = 15;
  localparam int IMPL_POS2 = 30;
  localparam int IMPL_POS3 = 31;

  // Reserved bits 10-13 and 16-29, as little-endian indices
  localparam logic [31:0] RSVD_MASK = 32'h003CFFFC;
  localparam logic [31:0] DATA_RST  = 32'h00000000;
  localparam logic [3:0]  ONE_WORD  = 4'h1;

  typedef enum logic [1:0] {SP_CAP, SP_CSR, SP_EXT, SP_IMPL} scr_space_type;
  typedef enum logic [1:0] {RS_DONE, RS_ERROR}               scr_status_type;
  typedef enum logic       {ST_IDLE, ST_READ}                scr_state_type;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [23:0] offset;
    logic [31:0] wdata;
    logic [3:0]  words;
  } scr_req_type;

  typedef struct packed {
    logic           valid;
    logic           write;
    logic           last;
    scr_status_type status;
    logic [31:0]    data;
  } scr_rsp_type;

  // Big-endian bit number to little-endian vector index
  function automatic int be_pos(input int n);
    return REG_W - 1 - n;
  endfunction

  // Position of the k-th implementation-defined flag
  function automatic int impl_pos(input int k);
    int p;
    p = IMPL_POS3;
    if (k == 0) p = IMPL_POS0;
    else if (k == 1) p = IMPL_POS1;
    else if (k == 2) p = IMPL_POS2;
    return p;
  endfunction

endpackage

// >>> rtl/scr_decode.sv
`timescale 1ns/100ps
module scr_decode
(
  input  wire logic [23:0]           offset,
  output scr_pkg::scr_space_type     space,
  output logic                       hit_src,
  output logic                       hit_tgt
);

  logic [23:0] word_ofs;

  // Byte lanes are dropped; every register sits on a word boundary
  assign word_ofs = {offset[23:scr_pkg::WORD_LSB], 2'h0};

  // Space classification by offset range
  always_comb
  begin
    if (word_ofs <= scr_pkg::CAP_LAST)
      space = scr_pkg::SP_CAP;
    else if (word_ofs <= scr_pkg::CSR_LAST)
      space = scr_pkg::SP_CSR;
    else if (word_ofs <= scr_pkg::EXT_LAST)
      space = scr_pkg::SP_EXT;
    else
      space = scr_pkg::SP_IMPL;
  end

  // Only two words in the whole map are defined
  assign hit_src = (word_ofs == scr_pkg::SRC_OPS_OFS);
  assign hit_tgt = (word_ofs == scr_pkg::TGT_OPS_OFS);

endmodule

// >>> rtl/scr_capword.sv
`timescale 1ns/100ps
module scr_capword
#(
  parameter logic [9:0] OPS    = 10'h3FF,
  parameter logic [3:0] IMPL   = 4'h0,
  parameter bit         ENABLE = 1'b1
)
(
  output logic [31:0] word
);

  // Constant word built at elaboration; reserved bits stay zero
  always_comb
  begin
    word = scr_pkg::DATA_RST;
    if (ENABLE)
    begin
      for (int i = 0; i < scr_pkg::OP_COUNT; i++)
        word[scr_pkg::be_pos(i)] = OPS[i];
      for (int k = 0; k < scr_pkg::IMPL_COUNT; k++)
        word[scr_pkg::be_pos(scr_pkg::impl_pos(k))] = IMPL[k];
    end
  end

endmodule

// >>> rtl/scr_top.sv
`timescale 1ns/100ps
// Behaviour
// - Registers are 32-bit, word-aligned offsets
// - Undefined offsets complete normally, no error
// - Capability space read-only, writes silently dropped
// - Reserved bits read zero, writes ignored
// - Reserved registers read zero, writes ignored
// - Implementation bits return build value, read-only
// - Implementation bit writes elsewhere: our choice
// - Implementation space behaviour is our choice
// - Word-unit reads; optional multi-word bursts
// - Bit 0 is the word's MSB
// - Offset 0x18 reports originated operations
// - Bits 10-13, 16-29 reserved zero
// - Offset 0x1C reports serviced operations
// - Every maintenance read and write answered
// - All other offsets behave as reserved
module scr_top
#(
  parameter logic [9:0] SRC_OPS     = 10'h3FF,
  parameter logic [9:0] TGT_OPS     = 10'h3FF,
  parameter logic [3:0] SRC_IMPL    = 4'h0,
  parameter logic [3:0] TGT_IMPL    = 4'h0,
  parameter bit         IS_ENDPOINT = 1'b1,
  parameter logic [3:0] MAX_WORDS   = 4'h8
)
(
  input  wire logic                  CLOCK,
  input  wire logic                  NRST,
  input  wire scr_pkg::scr_req_type  REQ,
  output logic                       REQ_READY,
  output scr_pkg::scr_rsp_type       RSP
);

  scr_pkg::scr_state_type state_ff;
  scr_pkg::scr_space_type space;
  scr_pkg::scr_rsp_type   rsp_ff;
  logic                   ready_ff;
  logic [23:0]            ptr_ff;
  logic [3:0]             cnt_ff;
  logic [23:0]            cur_ofs;
  logic                   hit_src;
  logic                   hit_tgt;
  logic [31:0]            src_word;
  logic [31:0]            tgt_word;
  logic [31:0]            nxt_data;
  logic [3:0]             req_words;
  logic                   accept;
  logic                   acc_rd;
  logic                   acc_wr;

  // Zero-length requests count as one word; long ones are clipped
  function automatic logic [3:0] clamp_words(input logic [3:0] w);
    logic [3:0] r;
    r = w;
    if (w == 4'h0)
      r = scr_pkg::ONE_WORD;
    else if (w > MAX_WORDS)
      r = MAX_WORDS;
    return r;
  endfunction

  // Request handshake terms
  assign req_words = clamp_words(REQ.words);
  assign accept    = REQ.valid && ready_ff && (state_ff == scr_pkg::ST_IDLE);
  assign acc_rd    = accept && !REQ.write;
  assign acc_wr    = accept && REQ.write;

  // One decoder serves both the first word and the burst pointer
  assign cur_ofs = (state_ff == scr_pkg::ST_READ) ? ptr_ff : REQ.offset;

  scr_decode u_decode
  (
    .offset  (cur_ofs),
    .space   (space),
    .hit_src (hit_src),
    .hit_tgt (hit_tgt)
  );

  scr_capword
  #(
    .OPS    (SRC_OPS),
    .IMPL   (SRC_IMPL),
    .ENABLE (1'b1)
  )
  u_src_word
  (
    .word (src_word)
  );

  // Switches have no target word; it then reads as a reserved one
  scr_capword
  #(
    .OPS    (TGT_OPS),
    .IMPL   (TGT_IMPL),
    .ENABLE (IS_ENDPOINT)
  )
  u_tgt_word
  (
    .word (tgt_word)
  );

  // Read data mux; everything outside the two words reads zero
  always_comb
  begin
    nxt_data = scr_pkg::DATA_RST;
    unique case (space)
      scr_pkg::SP_CAP:
      begin
        if (hit_src)
          nxt_data = src_word;
        else if (hit_tgt)
          nxt_data = tgt_word;
        else
          nxt_data = scr_pkg::DATA_RST;
      end
      scr_pkg::SP_CSR:
        nxt_data = scr_pkg::DATA_RST;
      scr_pkg::SP_EXT:
        nxt_data = scr_pkg::DATA_RST;
      scr_pkg::SP_IMPL:
        nxt_data = scr_pkg::DATA_RST;
    endcase
  end

  // Burst sequencer; writes never leave idle, so they store nothing
  always_ff @(posedge CLOCK)
  begin
    if (!NRST)
    begin
      state_ff <= scr_pkg::ST_IDLE;
      ptr_ff   <= 24'h000000;
      cnt_ff   <= 4'h0;
    end
    else
    begin
      unique case (state_ff)
        scr_pkg::ST_IDLE:
        begin
          if (acc_rd && (req_words > scr_pkg::ONE_WORD))
          begin
            state_ff <= scr_pkg::ST_READ;
            ptr_ff   <= REQ.offset + scr_pkg::WORD_STEP;
            cnt_ff   <= req_words - scr_pkg::ONE_WORD;
          end
        end
        scr_pkg::ST_READ:
        begin
          ptr_ff <= ptr_ff + scr_pkg::WORD_STEP;
          cnt_ff <= cnt_ff - scr_pkg::ONE_WORD;
          if (cnt_ff == scr_pkg::ONE_WORD)
            state_ff <= scr_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Ready drops during a burst and returns with its last word
  always_ff @(posedge CLOCK)
  begin
    if (!NRST)
      ready_ff <= 1'b0;
    else if (state_ff == scr_pkg::ST_IDLE)
      ready_ff <= !(acc_rd && (req_words > scr_pkg::ONE_WORD));
    else
      ready_ff <= (cnt_ff == scr_pkg::ONE_WORD);
  end

  // Response register; status is always done, never an error
  always_ff @(posedge CLOCK)
  begin
    if (!NRST)
    begin
      rsp_ff.valid  <= 1'b0;
      rsp_ff.write  <= 1'b0;
      rsp_ff.last   <= 1'b0;
      rsp_ff.status <= scr_pkg::RS_DONE;
      rsp_ff.data   <= scr_pkg::DATA_RST;
    end
    else
    begin
      rsp_ff.valid  <= accept || (state_ff == scr_pkg::ST_READ);
      rsp_ff.write  <= acc_wr;
      rsp_ff.last   <= acc_wr
                       || (acc_rd && (req_words == scr_pkg::ONE_WORD))
                       || ((state_ff == scr_pkg::ST_READ) && (cnt_ff == scr_pkg::ONE_WORD));
      rsp_ff.status <= scr_pkg::RS_DONE;
      // Write data is dropped everywhere, including CSR and impl bits
      if (acc_rd || (state_ff == scr_pkg::ST_READ))
        rsp_ff.data <= nxt_data;
      else
        rsp_ff.data <= scr_pkg::DATA_RST;
    end
  end

  assign REQ_READY = ready_ff;
  assign RSP       = rsp_ff;

  // Checks on the answering behaviour
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!NRST);

  chk_req_answered: assert property (
    accept |=> rsp_ff.valid
  ) else $error("accepted request got no response next cycle");

  chk_never_error: assert property (
    rsp_ff.valid |-> (rsp_ff.status == scr_pkg::RS_DONE)
  ) else $error("response carried an error status");

  chk_rsvd_bits_zero: assert property (
    (rsp_ff.valid && !rsp_ff.write) |-> ((rsp_ff.data & scr_pkg::RSVD_MASK) == 32'h00000000)
  ) else $error("reserved bit read back as one");

  chk_src_word: assert property (
    (acc_rd && (REQ.offset[23:2] == scr_pkg::SRC_OPS_OFS[23:2]))
      |=> (rsp_ff.data == src_word)
  ) else $error("originate word read back wrong");

  chk_tgt_word: assert property (
    (acc_rd && (REQ.offset[23:2] == scr_pkg::TGT_OPS_OFS[23:2]))
      |=> (rsp_ff.data == (IS_ENDPOINT ? tgt_word : 32'h00000000))
  ) else $error("target word read back wrong");

  chk_rsvd_reg_zero: assert property (
    (acc_rd && (req_words == 4'h1) && !hit_src && !hit_tgt) |=> (rsp_ff.data == 32'h00000000)
  ) else $error("reserved register read back nonzero");

  chk_write_dropped: assert property (
    acc_wr |=> (rsp_ff.write && rsp_ff.last && (rsp_ff.data == 32'h00000000)
               && (rsp_ff.status == scr_pkg::RS_DONE) && ready_ff)
  ) else $error("write not acknowledged cleanly");

  chk_two_word_burst: assert property (
    (acc_rd && (req_words == 4'h2))
      |=> (rsp_ff.valid && !rsp_ff.last && !ready_ff)
          ##1 (rsp_ff.valid && rsp_ff.last && ready_ff)
  ) else $error("two-word burst framed wrong");

  chk_burst_ready_low: assert property (
    (state_ff == scr_pkg::ST_READ) |-> (!ready_ff && rsp_ff.valid)
  ) else $error("request taken during a burst");

  chk_impl_space_zero: assert property (
    (acc_rd && (space == scr_pkg::SP_IMPL)) |=> (rsp_ff.data == 32'h00000000)
  ) else $error("implementation space read nonzero");

  chk_csr_space_zero: assert property (
    (acc_rd && (space == scr_pkg::SP_CSR)) |=> (rsp_ff.data == scr_pkg::DATA_RST)
  ) else $error("command space read nonzero");

  chk_ext_space_zero: assert property (
    (acc_rd && (space == scr_pkg::SP_EXT)) |=> (rsp_ff.data == scr_pkg::DATA_RST)
  ) else $error("extended space read nonzero");

  // Reset itself must leave the port quiet, so this one is never disabled
  chk_reset_quiet: assert property (
    disable iff (1'b0) !NRST |=> (!ready_ff && !rsp_ff.valid)
  ) else $error("port not quiet after reset");

  // Idle with ready low only follows reset; ready must come back at once
  chk_ready_returns: assert property (
    ((state_ff == scr_pkg::ST_IDLE) && !ready_ff) |=> ready_ff
  ) else $error("ready did not return in idle");

  // A new request may be taken while the last word stands
  chk_last_ready: assert property (
    (rsp_ff.valid && rsp_ff.last) |-> ready_ff
  ) else $error("ready low with the last word");

  chk_burst_first: assert property (
    (acc_rd && (req_words > scr_pkg::ONE_WORD)) |=> (rsp_ff.valid && !rsp_ff.last && !ready_ff)
  ) else $error("burst first word framed wrong");

  // Pointer wraps at the top of the space rather than saturating
  chk_ptr_step: assert property (
    (state_ff == scr_pkg::ST_READ) |=> (ptr_ff == ($past(ptr_ff) + scr_pkg::WORD_STEP))
  ) else $error("burst pointer did not step one word");

  chk_cnt_range: assert property (
    (state_ff == scr_pkg::ST_READ) |-> ((cnt_ff != 4'h0) && (cnt_ff < MAX_WORDS))
  ) else $error("burst count out of range");

  chk_write_stays_idle: assert property (
    acc_wr |=> ((state_ff == scr_pkg::ST_IDLE) && ready_ff)
  ) else $error("write started a burst");

  // Write acks are always single words
  chk_read_no_write: assert property (
    (rsp_ff.valid && !rsp_ff.last) |-> !rsp_ff.write
  ) else $error("write ack inside a burst");

  // Stale read data must not linger between responses
  chk_idle_data_zero: assert property (
    !rsp_ff.valid |-> (rsp_ff.data == scr_pkg::DATA_RST)
  ) else $error("data left on an idle response");

  chk_single_last: assert property (
    (acc_rd && (req_words == scr_pkg::ONE_WORD)) |=> (rsp_ff.last && !rsp_ff.write)
  ) else $error("single read not marked last");

endmodule

// >>> dv/scr_requester.sv
`timescale 1ns/100ps
// Remote requester: one maintenance request at a time, held until taken
module scr_requester
(
  input  wire logic                 clock,
  output scr_pkg::scr_req_type      req,
  input  wire logic                 req_ready,
  input  wire scr_pkg::scr_rsp_type rsp
);
  initial req = '0;

  // Drive after an edge, hold until ready is seen, then gather words to last
  task automatic xfer(input logic wr, input logic [23:0] ofs, input logic [3:0] words,
                      input logic [31:0] wd, output scr_pkg::scr_rsp_type got[$]);
    int i;
    got = {};
    @(posedge clock);
    req <= '{valid: 1'b1, write: wr, offset: ofs, wdata: wd, words: words};
    i = 0;
    do
    begin
      @(posedge clock);
      i++;
    end while (req_ready !== 1'b1 && i < 50);
    req <= ~req; // Released bus carries every field inverted, so valid drops
    i = 0;
    do
    begin
      @(posedge clock);
      i++;
      if (rsp.valid === 1'b1) got.push_back(rsp);
    end while (!(rsp.valid === 1'b1 && rsp.last === 1'b1) && i < 20);
  endtask

  // Read, mask to the defined bits, merge and write back so reserved bits survive
  task automatic update(input logic [23:0] ofs, input logic [31:0] keep,
                        input logic [31:0] val, output scr_pkg::scr_rsp_type got[$]);
    logic [31:0] w;
    xfer(1'b0, ofs, 4'h1, 32'h00000000, got);
    w = (got.size() > 0) ? got[0].data : 32'h00000000;
    w = (w & ~keep) | (val & keep);
    xfer(1'b1, ofs, 4'h1, w, got);
  endtask
endmodule

// >>> dv/testbench.sv
`timescale 1ns/100ps
`define CHECK(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; \
  $display("[ERR] %0t got %h expected %h", $time, (a), (b)); end end
module testbench;
  // Lopsided flag sets, so a reversed flag order shows up as a mismatch
  localparam logic [9:0] S_OPS  = 10'h2B1;
  localparam logic [9:0] T_OPS  = 10'h0C6;
  localparam logic [3:0] S_IMPL = 4'hC;
  localparam logic [3:0] T_IMPL = 4'h3;
  logic                 ready_sw;
  scr_pkg::scr_req_type req_sw;
  scr_pkg::scr_rsp_type rsp_sw;
  logic                 CLOCK;
  logic                 NRST;
  logic                 ready;
  scr_pkg::scr_req_type req;
  scr_pkg::scr_rsp_type rsp;
  scr_pkg::scr_rsp_type got[$];
  int                   n_fail;
  int                   tests_run;
  int                   cycles;
  logic [31:0]          src_w;
  logic [31:0]          tgt_w;
  logic [23:0]          rsv [10] = '{24'h000000, 24'h000014, 24'h000020, 24'h00003C,
    24'h000040, 24'h0000FC, 24'h000100, 24'h00FFFC, 24'h010000, 24'hFFFFFC};
  logic [23:0]          wofs [5] = '{24'h000018, 24'h00001C, 24'h00003C, 24'h0000FC, 24'h010000};

  scr_top #(.SRC_OPS(S_OPS), .TGT_OPS(T_OPS), .SRC_IMPL(S_IMPL), .TGT_IMPL(T_IMPL),
    .IS_ENDPOINT(1'b1), .MAX_WORDS(4'h8)) dut (.CLOCK(CLOCK), .NRST(NRST), .REQ(req),
    .REQ_READY(ready), .RSP(rsp));
  scr_requester peer (.clock(CLOCK), .req(req), .req_ready(ready), .rsp(rsp));

  // Switch build with default flags: its target word must read as reserved
  scr_top #(.IS_ENDPOINT(1'b0)) dut_sw (.CLOCK(CLOCK), .NRST(NRST), .REQ(req_sw),
    .REQ_READY(ready_sw), .RSP(rsp_sw));
  scr_requester peer_sw (.clock(CLOCK), .req(req_sw), .req_ready(ready_sw), .rsp(rsp_sw));

  initial
  begin
    CLOCK = 1'b0;
    forever #2 CLOCK = ~CLOCK;
  end

  // Expected word: flag n at bit 31-n, build-time flags at bits 17, 16, 1, 0
  function automatic logic [31:0] cap(input logic [9:0] ops, input logic [3:0] impl);
    logic [31:0] w;
    w = 32'h00000000;
    for (int n = 0; n < 10; n++)
      w[31 - n] = ops[n];
    w[17] = impl[0];
    w[16] = impl[1];
    w[1] = impl[2];
    w[0] = impl[3];
    return w;
  endfunction

  // Read words from ofs and compare every word, last marker and status
  task automatic rdn(input logic [23:0] ofs, input logic [3:0] words, input logic [31:0] e[$]);
    peer.xfer(1'b0, ofs, words, 32'h00000000, got);
    `CHECK(got.size(), e.size())
    foreach (got[i])
    begin
      if (i < e.size()) `CHECK(got[i].data, e[i])
      `CHECK(got[i].last, (i == e.size() - 1))
      `CHECK(got[i].write, 1'b0)
      `CHECK(got[i].status, scr_pkg::RS_DONE)
    end
  endtask

  // Write all ones; the ack must come clean and carry no data
  task automatic wr1(input logic [23:0] ofs);
    peer.xfer(1'b1, ofs, 4'h1, 32'hFFFFFFFF, got);
    `CHECK(got.size(), 1)
    if (got.size() == 1)
    begin
      `CHECK(got[0].write, 1'b1)
      `CHECK(got[0].last, 1'b1)
      `CHECK(got[0].status, scr_pkg::RS_DONE)
      `CHECK(got[0].data, 32'h00000000)
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Hang guard well above the hundred or so cycles the tests need
  always @(posedge CLOCK)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      n_fail++;
      $display("[ERR] %0t run timed out", $time);
      print_verdict();
    end
  end

  initial
  begin
    NRST = 1'b0;
    n_fail = 0;
    tests_run = 0;
    cycles = 0;
    src_w = cap(S_OPS, S_IMPL);
    tgt_w = cap(T_OPS, T_IMPL);
    repeat (6) @(posedge CLOCK);
    `CHECK({ready, rsp.valid}, 2'b00)
    NRST <= 1'b1;
    $display("test reset finished");
    rdn(24'h000018, 4'h1, {src_w});
    rdn(24'h00001C, 4'h1, {tgt_w});
    rdn(24'h00001B, 4'h1, {src_w});
    foreach (rsv[i]) rdn(rsv[i], 4'h1, {32'h00000000});
    $display("test reads finished");
    foreach (wofs[i]) wr1(wofs[i]);
    rdn(24'h000018, 4'h1, {src_w});
    rdn(24'h00001C, 4'h1, {tgt_w});
    peer.update(24'h000018, 32'hFFC00000, 32'h00000000, got);
    rdn(24'h000018, 4'h1, {src_w});
    $display("test writes finished");
    rdn(24'h000010, 4'h4, {32'h00000000, 32'h00000000, src_w, tgt_w});
    rdn(24'h00001C, 4'h0, {tgt_w});
    rdn(24'h000018, 4'hF, {src_w, tgt_w, 32'h00000000, 32'h00000000, 32'h00000000,
      32'h00000000, 32'h00000000, 32'h00000000});
    $display("test bursts finished");
    peer_sw.xfer(1'b0, 24'h00001C, 4'h1, 32'h00000000, got);
    `CHECK(got.size(), 1)
    if (got.size() == 1) `CHECK(got[0].data, 32'h00000000)
    peer_sw.xfer(1'b0, 24'h000018, 4'h1, 32'h00000000, got);
    `CHECK(got.size(), 1)
    if (got.size() == 1) `CHECK(got[0].data, cap(10'h3FF, 4'h0))
    $display("test switch finished");
    print_verdict();
  end
endmodule
